// [rtl/dscg_pkg.sv]
/*
  dscg_pkg: register map, field layout, reset values, bus codes and
  state encodings for the deep-sleep clock gating block.
  Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
*/
package dscg_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_DEEP_GATE  = 12'h128;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h200;
  localparam logic [11:0] OFF_IRQ_MASK   = 12'h204;

  // field positions inside the gating layout
  localparam int unsigned POS_PORT_A = 0;
  localparam int unsigned POS_PORT_H = 7;
  localparam int unsigned POS_MAC    = 28;
  localparam int unsigned POS_PHY    = 30;

  // implemented bits: phy, mac and ports a..h
  localparam logic [31:0] GATE_IMPL_MASK  = 32'h5000_00ff;
  localparam logic [31:0] DEEP_GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] IRQ_RESET       = 32'h0000_0000;

  // axi4-lite response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // decoded register selector
  typedef enum logic [3:0] {
    SEL_DEEP   = 4'h1,
    SEL_STATUS = 4'h2,
    SEL_MASK   = 4'h4,
    SEL_NONE   = 4'h8
  } dscg_sel_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } dscg_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_DATA = 2'h2
  } dscg_rd_state_t;

endpackage : dscg_pkg

// [rtl/dscg_gate_if.sv]
/*
  dscg_gate_if: carries the three gating words and the power mode from
  the register side to the enable selector, and the chosen enables back.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface dscg_gate_if;
  logic [31:0] run_gate;
  logic [31:0] sleep_gate;
  logic [31:0] deep_gate;
  logic        auto_sel;
  logic        sleep_mode;
  logic        deep_mode;
  logic [31:0] unit_en;

  modport ctrl (
    output run_gate, sleep_gate, deep_gate,
    output auto_sel, sleep_mode, deep_mode,
    input  unit_en
  );
  modport sel (
    input  run_gate, sleep_gate, deep_gate,
    input  auto_sel, sleep_mode, deep_mode,
    output unit_en
  );
endinterface : dscg_gate_if

// [rtl/dscg_gate_select.sv]
/*
  dscg_gate_select: picks the gating word that applies in the current
  power mode and registers the per-unit clock enables.
  Assumes mode inputs are synchronous and mutually consistent.
*/
`timescale 1ns/1ps
module dscg_gate_select (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // gating words and chosen enables
  dscg_gate_if.sel  gate
);

  logic [31:0] unit_en_reg;
  logic [31:0] unit_en_next;

  always_comb begin
    unit_en_next = gate.run_gate;                                // RULE10
    if (gate.auto_sel && gate.deep_mode) begin                   // RULE5
      unit_en_next = gate.deep_gate;                             // RULE4
    end else if (gate.auto_sel && gate.sleep_mode) begin         // RULE5
      unit_en_next = gate.sleep_gate;
    end
  end

  // all units unclocked until software enables them
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      unit_en_reg <= dscg_pkg::DEEP_GATE_RESET;                  // RULE3
    end else begin
      unit_en_reg <= unit_en_next & dscg_pkg::GATE_IMPL_MASK;    // RULE1
    end
  end

  assign gate.unit_en = unit_en_reg;

endmodule : dscg_gate_select

// [rtl/dscg_clock_gate.sv]
/*
  dscg_clock_gate: deep-sleep clock gating register with an AXI4-Lite
  slave, per-unit clock enables, gated-access fault answers and a
  sticky fault interrupt.
  Assumes run/sleep gating words and the auto-gating select come from
  the system control block, and peripheral accesses are flagged by the
  bus fabric with a unit index in the gating layout.
*/
//
// Contract
// RULE1: unit clocked while its enable bit is one, unclocked and off else.
// RULE2: access to an unclocked unit is answered with a bus fault.
// RULE3: all gating bits reset to zero, every unit starts unclocked.
// RULE4: this register governs gating only during deep sleep.
// RULE5: sleep gating words apply only when auto gating select is set.
// RULE6: bit 30 enables phy clock, bit 28 enables mac clock, both rw.
// RULE7: bits 0 to 7 enable ports a to h clocks, each rw.
// RULE8: reserved bits 31, 29, 27:8 read zero; software preserves them.
// RULE9: gating register sits at offset 0x128, 32-bit read/write.
// RULE10: outside sleep and deep sleep or without auto gating, run word applies.
`timescale 1ns/1ps
module dscg_clock_gate #(
  parameter int unsigned ADDR_W = 12
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic [2:0]        s_axi_awprot_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic [2:0]        s_axi_arprot_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // gating words and mode from system control
  input  wire logic [31:0]       run_clock_gate_2_in,
  input  wire logic [31:0]       sleep_clock_gate_2_in,
  input  wire logic              auto_clock_gate_select_in,
  input  wire logic              sleep_mode_in,
  input  wire logic              deep_sleep_mode_in,
  // per-unit clock enables
  output logic                   phy_unit_clock_enable_out,
  output logic                   mac_unit_clock_enable_out,
  output logic [7:0]             port_clock_enable_out,
  // peripheral access check
  input  wire logic              periph_req_in,
  input  wire logic [4:0]        periph_unit_in,
  output logic                   periph_ok_out,
  output logic                   periph_fault_out,
  // interrupt
  output logic                   irq_out
);

  // prot is accepted but not used for access checks
  logic [2:0] prot_unused;
  assign prot_unused = s_axi_awprot_in | s_axi_arprot_in;

  // decode a byte address to a register selector
  function automatic dscg_pkg::dscg_sel_t decode(
    input logic [ADDR_W-1:0] addr
  );
    logic [11:0] word;
    word = {addr[11:2], 2'h0};
    if (word == dscg_pkg::OFF_DEEP_GATE) begin                   // RULE9
      decode = dscg_pkg::SEL_DEEP;
    end else if (word == dscg_pkg::OFF_IRQ_STATUS) begin
      decode = dscg_pkg::SEL_STATUS;
    end else if (word == dscg_pkg::OFF_IRQ_MASK) begin
      decode = dscg_pkg::SEL_MASK;
    end else begin
      decode = dscg_pkg::SEL_NONE;
    end
  endfunction : decode

  // expand byte strobes into a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : strb_mask

  // merge written bytes into a stored word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    merge = (old & ~strb_mask(strb)) | (data & strb_mask(strb));
  endfunction : merge

  // registers
  logic [31:0] deep_sleep_clock_gate_2_reg;
  logic [31:0] irq_status_reg;
  logic [31:0] irq_mask_reg;

  // write channel state
  dscg_pkg::dscg_wr_state_t wr_state_reg;
  logic                     aw_held_reg;
  logic                     w_held_reg;
  logic [ADDR_W-1:0]        awaddr_reg;
  logic [31:0]              wdata_reg;
  logic [3:0]               wstrb_reg;
  logic [1:0]               bresp_reg;

  // read channel state
  dscg_pkg::dscg_rd_state_t rd_state_reg;
  logic [31:0]              rdata_reg;
  logic [1:0]               rresp_reg;

  // peripheral answer
  logic periph_ok_reg;
  logic periph_fault_reg;
  logic unit_on;

  // enables from selector
  dscg_gate_if gate ();

  logic              aw_fire;
  logic              w_fire;
  logic              wr_go;
  logic              ar_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  dscg_pkg::dscg_sel_t wr_sel;
  logic [31:0]       fault_set;
  logic [31:0]       status_clr;

  // address and data are taken in either order, one write at a time
  assign s_axi_awready_out = (wr_state_reg == dscg_pkg::WR_IDLE)
                             && !aw_held_reg;
  assign s_axi_wready_out  = (wr_state_reg == dscg_pkg::WR_IDLE)
                             && !w_held_reg;
  assign aw_fire = s_axi_awvalid_in && s_axi_awready_out;
  assign w_fire  = s_axi_wvalid_in && s_axi_wready_out;
  assign wr_go   = (wr_state_reg == dscg_pkg::WR_IDLE)
                   && (aw_held_reg || aw_fire) && (w_held_reg || w_fire);
  assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr_in;
  assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata_in;
  assign wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb_in;
  assign wr_sel  = decode(wr_addr);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else if (wr_go) begin
      aw_held_reg <= 1'b0;
    end else if (aw_fire) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else if (wr_go) begin
      w_held_reg <= 1'b0;
    end else if (w_fire) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata_in;
      wstrb_reg  <= s_axi_wstrb_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_state_reg <= dscg_pkg::WR_IDLE;
      bresp_reg    <= dscg_pkg::RESP_OKAY;
    end else begin
      unique case (wr_state_reg)
        dscg_pkg::WR_IDLE: begin
          if (wr_go) begin
            wr_state_reg <= dscg_pkg::WR_RESP;
            bresp_reg    <= (wr_sel == dscg_pkg::SEL_NONE)
                            ? dscg_pkg::RESP_DECERR : dscg_pkg::RESP_OKAY;
          end
        end
        dscg_pkg::WR_RESP: begin
          if (s_axi_bready_in) begin
            wr_state_reg <= dscg_pkg::WR_IDLE;
          end
        end
        // a corrupt one-hot code falls back to idle
        default: begin
          wr_state_reg <= dscg_pkg::WR_IDLE;
        end
      endcase
    end
  end

  assign s_axi_bvalid_out = (wr_state_reg == dscg_pkg::WR_RESP);
  assign s_axi_bresp_out  = bresp_reg;

  // gating register, only implemented bits store
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      deep_sleep_clock_gate_2_reg <= dscg_pkg::DEEP_GATE_RESET;  // RULE3
    end else if (wr_go && wr_sel == dscg_pkg::SEL_DEEP) begin
      deep_sleep_clock_gate_2_reg <=
        merge(deep_sleep_clock_gate_2_reg, wr_data, wr_strb)  // RULE6 RULE7
        & dscg_pkg::GATE_IMPL_MASK;                           // RULE8
    end
  end

  // mask shares the gating layout
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_mask_reg <= dscg_pkg::IRQ_RESET;
    end else if (wr_go && wr_sel == dscg_pkg::SEL_MASK) begin
      irq_mask_reg <= merge(irq_mask_reg, wr_data, wr_strb)
                      & dscg_pkg::GATE_IMPL_MASK;
    end
  end

  // sticky fault bits, write one to clear, a new fault wins
  // absent units lie outside the mask and leave no trace
  assign status_clr = (wr_go && wr_sel == dscg_pkg::SEL_STATUS)
                      ? (wr_data & strb_mask(wr_strb)) : 32'h0000_0000;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_status_reg <= dscg_pkg::IRQ_RESET;
    end else begin
      irq_status_reg <= ((irq_status_reg & ~status_clr) | fault_set)
                        & dscg_pkg::GATE_IMPL_MASK;
    end
  end

  assign irq_out = |(irq_status_reg & irq_mask_reg);

  // read channel, data one cycle after address
  assign s_axi_arready_out = (rd_state_reg == dscg_pkg::RD_IDLE);
  assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_state_reg <= dscg_pkg::RD_IDLE;
      rdata_reg    <= '0;
      rresp_reg    <= dscg_pkg::RESP_OKAY;
    end else begin
      unique case (rd_state_reg)
        dscg_pkg::RD_IDLE: begin
          if (ar_fire) begin
            rd_state_reg <= dscg_pkg::RD_DATA;
            rresp_reg    <= dscg_pkg::RESP_OKAY;
            unique case (decode(s_axi_araddr_in))
              dscg_pkg::SEL_DEEP: begin
                rdata_reg <= deep_sleep_clock_gate_2_reg;        // RULE8
              end
              dscg_pkg::SEL_STATUS: begin
                rdata_reg <= irq_status_reg;
              end
              dscg_pkg::SEL_MASK: begin
                rdata_reg <= irq_mask_reg;
              end
              dscg_pkg::SEL_NONE: begin
                rdata_reg <= '0;
                rresp_reg <= dscg_pkg::RESP_DECERR;
              end
            endcase
          end
        end
        dscg_pkg::RD_DATA: begin
          if (s_axi_rready_in) begin
            rd_state_reg <= dscg_pkg::RD_IDLE;
          end
        end
        // a corrupt one-hot code falls back to idle
        default: begin
          rd_state_reg <= dscg_pkg::RD_IDLE;
        end
      endcase
    end
  end

  assign s_axi_rvalid_out = (rd_state_reg == dscg_pkg::RD_DATA);
  assign s_axi_rdata_out  = rdata_reg;
  assign s_axi_rresp_out  = rresp_reg;

  // enable selection per power mode
  assign gate.run_gate   = run_clock_gate_2_in;
  assign gate.sleep_gate = sleep_clock_gate_2_in;
  assign gate.deep_gate  = deep_sleep_clock_gate_2_reg;
  assign gate.auto_sel   = auto_clock_gate_select_in;
  assign gate.sleep_mode = sleep_mode_in;
  assign gate.deep_mode  = deep_sleep_mode_in;

  dscg_gate_select u_select (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .gate      (gate.sel)
  );

  assign phy_unit_clock_enable_out = gate.unit_en[dscg_pkg::POS_PHY];  // RULE1
  assign mac_unit_clock_enable_out = gate.unit_en[dscg_pkg::POS_MAC];  // RULE1
  assign port_clock_enable_out =
    gate.unit_en[dscg_pkg::POS_PORT_H:dscg_pkg::POS_PORT_A];           // RULE1

  // enable of the addressed unit, absent units read as off
  assign unit_on = gate.unit_en[periph_unit_in];

  // access to an unclocked or absent unit faults
  always_comb begin
    fault_set = 32'h0000_0000;
    if (periph_req_in && !unit_on) begin                              // RULE2
      fault_set[periph_unit_in] = 1'b1;
    end
  end

  // one-cycle answer after the request edge
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      periph_ok_reg    <= 1'b0;
      periph_fault_reg <= 1'b0;
    end else begin
      periph_ok_reg    <= periph_req_in && unit_on;                   // RULE1
      periph_fault_reg <= periph_req_in && !unit_on;                  // RULE2
    end
  end

  assign periph_ok_out    = periph_ok_reg;
  assign periph_fault_out = periph_fault_reg;

endmodule : dscg_clock_gate

// [sim/dscg_clock_gate_sva.sv]
/*
  dscg_clock_gate_sva: port-level checks of the deep-sleep gating block.
  Assumes it is bound onto dscg_clock_gate with one clock.
*/
`timescale 1ns/1ps
module dscg_clock_gate_sva #(
  parameter int unsigned ADDR_W = 12
) (
  // clock and reset
  input wire logic              clk_in,
  input wire logic              resetn_in,
  // bus handshakes
  input wire logic              s_axi_awvalid_in,
  input wire logic              s_axi_awready_out,
  input wire logic              s_axi_wvalid_in,
  input wire logic              s_axi_wready_out,
  input wire logic              s_axi_bvalid_out,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic              s_axi_arvalid_in,
  input wire logic              s_axi_arready_out,
  input wire logic [31:0]       s_axi_rdata_out,
  input wire logic              s_axi_rvalid_out,
  // gating words and mode
  input wire logic [31:0]       run_clock_gate_2_in,
  input wire logic [31:0]       sleep_clock_gate_2_in,
  input wire logic              auto_clock_gate_select_in,
  input wire logic              sleep_mode_in,
  input wire logic              deep_sleep_mode_in,
  // enables and access check
  input wire logic              phy_unit_clock_enable_out,
  input wire logic              mac_unit_clock_enable_out,
  input wire logic [7:0]        port_clock_enable_out,
  input wire logic              periph_req_in,
  input wire logic [4:0]        periph_unit_in,
  input wire logic              periph_ok_out,
  input wire logic              periph_fault_out
);
  logic [31:0]       en_w;
  logic [ADDR_W-1:0] rd_addr_reg;

  assign en_w = {1'b0, phy_unit_clock_enable_out, 1'b0,
                 mac_unit_clock_enable_out, 20'h0, port_clock_enable_out};

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) rd_addr_reg <= '0;
    else if (s_axi_arvalid_in && s_axi_arready_out)
      rd_addr_reg <= s_axi_araddr_in;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  chk_fault_gated_unit: assert property (
    periph_req_in && !en_w[periph_unit_in]
    |=> periph_fault_out && !periph_ok_out) else $error("no fault");
  chk_ok_clocked_unit: assert property (
    periph_req_in && en_w[periph_unit_in]
    |=> periph_ok_out && !periph_fault_out) else $error("no ok");
  chk_no_stray_pulse: assert property (
    !periph_req_in |=> !periph_ok_out && !periph_fault_out)
    else $error("stray access pulse");
  chk_run_word_used: assert property (
    !auto_clock_gate_select_in |=>
    en_w == ($past(run_clock_gate_2_in) & dscg_pkg::GATE_IMPL_MASK))
    else $error("run word not applied");
  chk_sleep_word_used: assert property (
    auto_clock_gate_select_in && sleep_mode_in && !deep_sleep_mode_in |=>
    en_w == ($past(sleep_clock_gate_2_in) & dscg_pkg::GATE_IMPL_MASK))
    else $error("sleep word not applied");
  chk_write_answer: assert property (
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
    s_axi_wready_out |=> s_axi_bvalid_out) else $error("late bvalid");
  chk_read_answer: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("late rvalid");
  chk_reserved_zero: assert property (
    s_axi_rvalid_out && rd_addr_reg == dscg_pkg::OFF_DEEP_GATE |->
    (s_axi_rdata_out & ~dscg_pkg::GATE_IMPL_MASK) == 32'h0)
    else $error("reserved bits set");
endmodule : dscg_clock_gate_sva

bind dscg_clock_gate dscg_clock_gate_sva #(.ADDR_W(ADDR_W))
  dscg_clock_gate_sva_inst (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rvalid_out(s_axi_rvalid_out),
    .run_clock_gate_2_in(run_clock_gate_2_in),
    .sleep_clock_gate_2_in(sleep_clock_gate_2_in),
    .auto_clock_gate_select_in(auto_clock_gate_select_in),
    .sleep_mode_in(sleep_mode_in),
    .deep_sleep_mode_in(deep_sleep_mode_in),
    .phy_unit_clock_enable_out(phy_unit_clock_enable_out),
    .mac_unit_clock_enable_out(mac_unit_clock_enable_out),
    .port_clock_enable_out(port_clock_enable_out),
    .periph_req_in(periph_req_in), .periph_unit_in(periph_unit_in),
    .periph_ok_out(periph_ok_out), .periph_fault_out(periph_fault_out));

// [sim/test_deep_sleep_clock_gating.sv]
/*
  test_deep_sleep_clock_gating: self-checking bench for dscg_clock_gate.
  Assumes the bound checker and the package are compiled first.
*/
`timescale 1ns/1ps
module test_deep_sleep_clock_gating;
  typedef struct {
    logic        a, s, d;
    logic [31:0] run, slp, exp;
  } dscg_row_t;
  logic        clk_in, resetn_in, awvalid, wvalid, arvalid, awready;
  logic        wready, bvalid, arready, rvalid, phy, mac, ok, fault, irq;
  logic        auto_sel, slp_mode, deep_mode, req;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, run_w, slp_w, rdata, en_w, data;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  port;
  logic [4:0]  unit;
  int          n_mismatch, cmp_count;
  int          pos [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 28, 30};
  dscg_row_t   rows [6] = '{
    '{1'b0, 1'b0, 1'b1, 32'h0000_00a5, 32'h0, 32'h0000_00a5},
    '{1'b1, 1'b0, 1'b1, 32'h0000_00a5, 32'h11, 32'h5000_00ff},
    '{1'b1, 1'b1, 1'b0, 32'h0, 32'h1000_003c, 32'h1000_003c},
    '{1'b0, 1'b1, 1'b0, 32'h4000_0001, 32'h1000_003c, 32'h4000_0001},
    '{1'b1, 1'b0, 1'b0, 32'hffff_ff00, 32'h0, 32'h5000_0000},
    '{1'b1, 1'b1, 1'b1, 32'h0, 32'h1000_003c, 32'h5000_00ff}};

  assign en_w = {1'b0, phy, 1'b0, mac, 20'h0, port};

  dscg_clock_gate dscg_clock_gate_inst (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awprot_in(3'h0),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(1'b1), .s_axi_araddr_in(araddr),
    .s_axi_arprot_in(3'h0), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(1'b1), .run_clock_gate_2_in(run_w),
    .sleep_clock_gate_2_in(slp_w), .auto_clock_gate_select_in(auto_sel),
    .sleep_mode_in(slp_mode), .deep_sleep_mode_in(deep_mode),
    .phy_unit_clock_enable_out(phy), .mac_unit_clock_enable_out(mac),
    .port_clock_enable_out(port), .periph_req_in(req),
    .periph_unit_in(unit), .periph_ok_out(ok),
    .periph_fault_out(fault), .irq_out(irq));

  always #12.5 clk_in = ~clk_in;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  // entered and left just after a rising edge; ready sampled mid-cycle
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; tb = 1'b0;
    while (!tb) begin
      @(negedge clk_in);
      ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; resp = bresp;
      @(posedge clk_in);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a);
    logic ta, tr;
    araddr <= a; arvalid <= 1'b1; tr = 1'b0;
    while (!tr) begin
      @(negedge clk_in);
      ta = arvalid & arready; tr = rvalid; data = rdata; resp = rresp;
      @(posedge clk_in);
      if (ta) arvalid <= 1'b0;
    end
  endtask : axi_rd

  task automatic periph(input logic [4:0] u, input logic [1:0] exp);
    req <= 1'b1; unit <= u;
    @(posedge clk_in);
    req <= 1'b0;
    @(negedge clk_in);
    check({30'h0, ok, fault}, {30'h0, exp});
    @(posedge clk_in);
  endtask : periph

  task automatic settle;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
  endtask : settle

  initial begin
    repeat (5000) @(posedge clk_in);
    n_mismatch++;
    close_out();
  end

  initial begin
    {clk_in, resetn_in, awvalid, wvalid, arvalid, req} = '0;
    {auto_sel, slp_mode, deep_mode, awaddr, araddr, unit} = '0;
    {wdata, run_w, slp_w} = '0;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
    check(en_w, 32'h0);
    check({31'h0, irq}, 32'h0);
    @(posedge clk_in);
    axi_rd(12'h128); check(data, 32'h0);
    axi_wr(12'h128, 32'hffff_ffff); check({30'h0, resp}, 32'h0);
    axi_rd(12'h128); check(data, 32'h5000_00ff);
    $display("test reset and access done");
    foreach (rows[i]) begin
      auto_sel <= rows[i].a; slp_mode <= rows[i].s; deep_mode <= rows[i].d;
      run_w <= rows[i].run; slp_w <= rows[i].slp;
      settle();
      check(en_w, rows[i].exp);
      @(posedge clk_in);
    end
    $display("test mode selection done");
    auto_sel <= 1'b1; slp_mode <= 1'b0; deep_mode <= 1'b1;
    foreach (pos[i]) begin
      axi_wr(12'h128, 32'h1 << pos[i]);
      settle();
      check(en_w, 32'h1 << pos[i]);
      @(posedge clk_in);
      periph(5'(pos[i]), 2'b10);
      periph(5'(pos[i] + 1), 2'b01);
    end
    $display("test per-unit gating done");
    axi_wr(12'h200, 32'hffff_ffff);
    axi_wr(12'h204, 32'h8);
    axi_wr(12'h128, 32'h0);
    settle(); check({31'h0, irq}, 32'h0);
    @(posedge clk_in);
    periph(5'd3, 2'b01);
    periph(5'd2, 2'b01);
    check({31'h0, irq}, 32'h1);
    axi_rd(12'h200); check(data, 32'hc);
    axi_wr(12'h200, 32'h8);
    settle(); check({31'h0, irq}, 32'h0);
    @(posedge clk_in);
    axi_rd(12'h200); check(data, 32'h4);
    axi_wr(12'h300, 32'h1); check({30'h0, resp}, 32'h3);
    axi_rd(12'h300); check({data[29:0], resp}, 32'h3);
    $display("test fault interrupt and unmapped done");
    axi_wr(12'h128, 32'h5000_00ff);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
    check(en_w, 32'h0);
    @(posedge clk_in);
    axi_rd(12'h128); check(data, 32'h0);
    axi_rd(12'h200); check(data, 32'h0);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : test_deep_sleep_clock_gating
